// *** rmlvm_top.v ***
// regulator mode control, supervisor gating and control/status registers
// assumes: bus strobes are one cycle and synchronous to i_mclk;
// stop and enable pin are synchronous; comparator results are not
`timescale 1ns/1ps
`include "rmlvm_map.vh"

module rmlvm_top (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [`RMLVM_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire i_stop_mode,
  input wire i_regulator_enable_pin,
  input wire i_vdda_below_det_assert,
  input wire i_vdda_above_det_deassert,
  input wire i_vdd_below_lvr_assert,
  input wire i_vdd_above_lvr_deassert,
  input wire i_vdd_below_por,
  output reg [7:0] o_rd_data,
  output reg o_low_voltage_interrupt,
  output reg o_irq,
  output reg o_low_voltage_reset_out,
  output reg o_por_out,
  output reg [1:0] o_mode,
  output reg o_reg_outputs_drive,
  output reg o_low_voltage_detector_active,
  output reg o_low_voltage_reset_active
);

  // ==========================================================
  // comparator synchronization
  wire [`RMLVM_SYNC_W-1:0] cmp_raw;
  wire [`RMLVM_SYNC_W-1:0] cmp_s;

  // power-on bit enters inverted, so a flushed synchronizer reads "below": no false release
  assign cmp_raw = {~i_vdd_below_por, i_vdd_above_lvr_deassert, i_vdd_below_lvr_assert,
                    i_vdda_above_det_deassert, i_vdda_below_det_assert};

  rmlvm_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(cmp_raw),
    .o_sync(cmp_s)
  );

  // ==========================================================
  // hysteresis helper
  // below the assertion level sets, above deassertion clears, else holds
  function hyst_next;
    input cur;
    input below_assert;
    input above_deassert;
    begin
      if (below_assert) begin
        hyst_next = 1'b1;
      end else if (above_deassert) begin
        hyst_next = 1'b0;
      end else begin
        hyst_next = cur;
      end
    end
  endfunction

  // ==========================================================
  // operating mode
  localparam [1:0] MODE_SHUTDOWN = `RMLVM_MODE_SHUTDOWN;
  localparam [1:0] MODE_FULL = `RMLVM_MODE_FULL;
  localparam [1:0] MODE_REDUCED = `RMLVM_MODE_REDUCED;

  reg [1:0] mode_q;
  reg [1:0] mode_d;

  // the enable pin is assumed static while powered, so no debounce here
  always @* begin
    case ({i_regulator_enable_pin, i_stop_mode})
      2'b10: begin
        mode_d = MODE_FULL;
      end
      2'b11: begin
        mode_d = MODE_REDUCED;
      end
      2'b00, 2'b01: begin
        mode_d = MODE_SHUTDOWN;
      end
      default: begin
        mode_d = MODE_SHUTDOWN;
      end
    endcase
  end

  wire full_d;
  assign full_d = (mode_d == MODE_FULL);

  // ==========================================================
  // supervisor state
  reg det_stat_q;
  reg det_stat_d;
  reg lvr_q;
  reg lvr_d;
  reg por_q;

  always @* begin
    // outside full mode both monitors are switched off and read zero
    if (full_d) begin
      det_stat_d = hyst_next(det_stat_q, cmp_s[`RMLVM_CMP_DET_A],
                             cmp_s[`RMLVM_CMP_DET_D]);
      lvr_d = hyst_next(lvr_q, cmp_s[`RMLVM_CMP_LVR_A],
                        cmp_s[`RMLVM_CMP_LVR_D]);
    end else begin
      det_stat_d = 1'b0;
      lvr_d = 1'b0;
    end
  end

  wire det_change;
  wire lvr_rise;
  wire por_rise;

  assign det_change = det_stat_d ^ det_stat_q;
  assign lvr_rise = lvr_d & ~lvr_q;
  assign por_rise = ~cmp_s[`RMLVM_CMP_POR] & ~por_q;

  // ==========================================================
  // register bus decode
  wire wr_ctrl;
  wire wr_mask;
  wire rd_status;

  assign wr_ctrl = i_wr_stb && (i_addr == `RMLVM_OFS_CTRL);
  assign wr_mask = i_wr_stb && (i_addr == `RMLVM_OFS_IRQ_MASK);
  assign rd_status = i_rd_stb && (i_addr == `RMLVM_OFS_IRQ_STATUS);

  // ==========================================================
  // control register and event registers
  reg irq_en_q;
  reg chg_flag_q;
  reg chg_flag_d;
  reg [`RMLVM_EVT_W-1:0] evt_q;
  reg [`RMLVM_EVT_W-1:0] evt_d;
  reg [`RMLVM_EVT_W-1:0] mask_q;
  wire [`RMLVM_EVT_W-1:0] evt_set;

  assign evt_set = {por_rise, lvr_rise, det_change};

  always @* begin
    chg_flag_d = chg_flag_q;
    // write one clears; a change in the same cycle still wins
    if (wr_ctrl && i_wr_data[`RMLVM_CTRL_CHG_FLAG]) begin
      chg_flag_d = 1'b0;
    end
    if (det_change) begin
      chg_flag_d = 1'b1;
    end
    // a mode change that changes detect status also sets the flag
    evt_d = evt_q;
    if (rd_status) begin
      evt_d = {`RMLVM_EVT_W{1'b0}};
    end
    evt_d = evt_d | evt_set;
  end

  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode_q <= MODE_SHUTDOWN;
      det_stat_q <= 1'b0;
      lvr_q <= 1'b0;
      por_q <= 1'b1;
      irq_en_q <= `RMLVM_RST_IRQ_EN;
      chg_flag_q <= 1'b0;
      evt_q <= {`RMLVM_EVT_W{1'b0}};
      mask_q <= `RMLVM_RST_MASK;
    end else begin
      mode_q <= mode_d;
      det_stat_q <= det_stat_d;
      lvr_q <= lvr_d;
      por_q <= ~cmp_s[`RMLVM_CMP_POR];
      if (wr_ctrl) begin
        irq_en_q <= i_wr_data[`RMLVM_CTRL_IRQ_EN];
      end
      chg_flag_q <= chg_flag_d;
      evt_q <= evt_d;
      if (wr_mask) begin
        mask_q <= i_wr_data[`RMLVM_EVT_W-1:0];
      end
    end
  end

  // ==========================================================
  // read path
  // detect status bit only ever comes from the monitor, not the bus
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (i_addr)
      `RMLVM_OFS_CTRL: begin
        rd_mux[`RMLVM_CTRL_DET_STAT] = det_stat_q;
        rd_mux[`RMLVM_CTRL_IRQ_EN] = irq_en_q;
        rd_mux[`RMLVM_CTRL_CHG_FLAG] = chg_flag_q;
      end
      `RMLVM_OFS_IRQ_STATUS: begin
        rd_mux[`RMLVM_EVT_W-1:0] = evt_q;
      end
      `RMLVM_OFS_IRQ_MASK: begin
        rd_mux[`RMLVM_EVT_W-1:0] = mask_q;
      end
      `RMLVM_OFS_MODE: begin
        rd_mux[1:0] = mode_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // registered outputs
  // outputs lag the internal state by one cycle so all come from flops
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
      o_low_voltage_interrupt <= 1'b0;
      o_irq <= 1'b0;
      o_low_voltage_reset_out <= 1'b0;
      o_por_out <= 1'b1;
      o_mode <= MODE_SHUTDOWN;
      o_reg_outputs_drive <= 1'b0;
      o_low_voltage_detector_active <= 1'b0;
      o_low_voltage_reset_active <= 1'b0;
    end else begin
      o_rd_data <= i_rd_stb ? rd_mux : 8'h00;
      o_low_voltage_interrupt <= irq_en_q & chg_flag_q;
      o_irq <= |(evt_q & mask_q);
      o_low_voltage_reset_out <= lvr_q;
      o_por_out <= por_q;
      o_mode <= mode_q;
      o_reg_outputs_drive <= (mode_q != MODE_SHUTDOWN);
      o_low_voltage_detector_active <= (mode_q == MODE_FULL);
      o_low_voltage_reset_active <= (mode_q == MODE_FULL);
    end
  end

endmodule

// *** rmlvm_map.vh ***
// constants of the regulator mode and low-voltage monitor block
// assumes: included by the design files, one 200 MHz bus clock
//
// What this block does
// - detect status is read-only at bit 2; writes leave it unchanged.
// - status sets below assertion level, clears above deassertion, full-performance mode only.
// - change flag at bit 0 sets on every detect status change.
// - change flag clears only by writing one; writing zero does nothing.
// - enable bit 1 gates the change flag onto the interrupt request.
// - entering reduced-power mode sets the change flag if detect status was one.
// - enabled and not stopped means full mode with detect, reset, power-on.
// - stop mode with enable pin high means reduced-power mode; only power-on reset stays active.
// - enable pin low means shutdown, outputs high impedance, power-on only.
// - enable pin high selects full or reduced mode from stop state.
// - low-voltage reset asserts below assertion, negates above deassertion, full mode only.
// - power-on reset output high while supply below threshold, all modes.
`ifndef RMLVM_MAP_VH
`define RMLVM_MAP_VH

// ==========================================================
// register offsets
`define RMLVM_ADDR_W 8
`define RMLVM_OFS_CTRL 8'h00
`define RMLVM_OFS_IRQ_STATUS 8'h01
`define RMLVM_OFS_IRQ_MASK 8'h02
`define RMLVM_OFS_MODE 8'h03

// ==========================================================
// control register fields
`define RMLVM_CTRL_CHG_FLAG 0
`define RMLVM_CTRL_IRQ_EN 1
`define RMLVM_CTRL_DET_STAT 2

// ==========================================================
// event status / mask fields
`define RMLVM_EVT_W 3
`define RMLVM_EVT_DET_CHG 0
`define RMLVM_EVT_LVR 1
`define RMLVM_EVT_POR 2

// ==========================================================
// mode codes and reset values
`define RMLVM_MODE_SHUTDOWN 2'h0
`define RMLVM_MODE_FULL 2'h1
`define RMLVM_MODE_REDUCED 2'h2
`define RMLVM_RST_IRQ_EN 1'h0
`define RMLVM_RST_MASK 3'h0

// ==========================================================
// comparator synchronizer
`define RMLVM_SYNC_W 5
`define RMLVM_CMP_DET_A 0
`define RMLVM_CMP_DET_D 1
`define RMLVM_CMP_LVR_A 2
`define RMLVM_CMP_LVR_D 3
`define RMLVM_CMP_POR 4

`endif

// *** rmlvm_sync.v ***
// two-flop synchronizer for the analog comparator results
// assumes: inputs are asynchronous levels, one clock, synchronous reset
`timescale 1ns/1ps
`include "rmlvm_map.vh"

module rmlvm_sync (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [`RMLVM_SYNC_W-1:0] i_async,
  output reg [`RMLVM_SYNC_W-1:0] o_sync
);

  reg [`RMLVM_SYNC_W-1:0] meta_q;

  // first stage is read only by the second stage
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_q <= {`RMLVM_SYNC_W{1'b0}};
      o_sync <= {`RMLVM_SYNC_W{1'b0}};
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// *** rmlvm_monitor.sv ***
// port assertions for rmlvm_top
// assumes: bound to rmlvm_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
module rmlvm_monitor (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire i_rd_stb,
  input wire i_stop_mode,
  input wire i_regulator_enable_pin,
  input wire i_vdd_below_lvr_assert,
  input wire i_vdd_below_por,
  input wire [7:0] o_rd_data,
  input wire o_low_voltage_reset_out,
  input wire o_por_out,
  input wire [1:0] o_mode,
  input wire o_reg_outputs_drive,
  input wire o_low_voltage_detector_active,
  input wire o_low_voltage_reset_active
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // mode gating
  sequence s_not_full;
    o_mode != 2'h1;
  endsequence
  sequence s_ctrl_rd;
    i_rd_stb && i_addr == 8'h00;
  endsequence
  property p_full;
    (i_regulator_enable_pin && !i_stop_mode)[*2] |=> o_mode == 2'h1 && o_reg_outputs_drive
      && o_low_voltage_detector_active && o_low_voltage_reset_active;
  endproperty
  a_full: assert property (p_full) else $error("full mode outputs wrong");
  property p_reduced;
    (i_regulator_enable_pin && i_stop_mode)[*2] |=> o_mode == 2'h2 && o_reg_outputs_drive
      && !o_low_voltage_detector_active && !o_low_voltage_reset_active;
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced mode outputs wrong");
  property p_shut;
    (!i_regulator_enable_pin)[*2] |=> o_mode == 2'h0 && !o_reg_outputs_drive
      && !o_low_voltage_detector_active && !o_low_voltage_reset_active;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown outputs wrong");
  // ==========================================================
  // supervisors
  property p_lvr_gate;
    s_not_full[*3] |-> !o_low_voltage_reset_out;
  endproperty
  a_lvr_gate: assert property (p_lvr_gate) else $error("reset out outside full");
  property p_lvr_on;
    (o_mode == 2'h1 && i_regulator_enable_pin && !i_stop_mode
      && i_vdd_below_lvr_assert)[*5] |=> o_low_voltage_reset_out;
  endproperty
  a_lvr_on: assert property (p_lvr_on) else $error("reset out missing");
  property p_por;
    $stable(i_vdd_below_por)[*4] |=> o_por_out == i_vdd_below_por;
  endproperty
  a_por: assert property (p_por) else $error("power-on out wrong");
  // ==========================================================
  // register reads
  property p_det_gate;
    s_not_full[*4] ##0 s_ctrl_rd |=> !o_rd_data[2];
  endproperty
  a_det_gate: assert property (p_det_gate) else $error("detect set outside full");
  property p_rd_idle;
    !i_rd_stb |=> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule
bind rmlvm_top rmlvm_monitor rmlvm_monitor_inst (.*);

// *** test_rmlvm_top.sv ***
// self-checking bench for rmlvm_top
// assumes: rmlvm_monitor bound beside it, one 200 MHz clock
`timescale 1ns/1ps
module test_rmlvm_top;
  logic i_mclk = 1'h0, i_rst_n = 1'h0, i_wr_stb = 1'h0, i_rd_stb = 1'h0, i_stop_mode = 1'h0;
  logic i_regulator_enable_pin = 1'h1;
  logic i_vdda_below_det_assert = 1'h0, i_vdda_above_det_deassert = 1'h1;
  logic i_vdd_below_lvr_assert = 1'h0, i_vdd_above_lvr_deassert = 1'h1, i_vdd_below_por = 1'h0;
  logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data;
  logic [1:0] o_mode;
  logic o_low_voltage_interrupt, o_irq, o_low_voltage_reset_out, o_por_out;
  logic o_reg_outputs_drive, o_low_voltage_detector_active, o_low_voltage_reset_active;
  int errors = 0, checks = 0;
  rmlvm_top rmlvm_top_inst (.*);
  initial forever #2.5 i_mclk = ~i_mclk;
  // ==========================================================
  // bus tasks
  task automatic chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // drive just after the edge so nothing races the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'h1;
    cyc(1);
    i_wr_stb <= 1'h0;
    // idle edge so the next call never re-drives the strobe in this time step
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, e);
    i_addr <= a;
    i_rd_stb <= 1'h1;
    cyc(1);
    i_rd_stb <= 1'h0;
    chk("rd_data", o_rd_data, e);
    cyc(1);
  endtask
  task automatic det(input logic b);
    i_vdda_below_det_assert <= b;
    i_vdda_above_det_deassert <= !b;
    cyc(6);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    cyc(4);
    i_rst_n <= 1'h1;
    cyc(4);
    chk("mode", o_mode, 8'h01);
    chk("drive", o_reg_outputs_drive, 8'h01);
    chk("por", o_por_out, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h02, 8'h01);
    $display("reset test done");
    det(1'h1);
    chk("irq", o_irq, 8'h01);
    rd(8'h00, 8'h05);
    rd(8'h01, 8'h01);
    cyc(1);
    chk("irq", o_irq, 8'h00);
    chk("lvi", o_low_voltage_interrupt, 8'h00);
    wr(8'h00, 8'h04);
    rd(8'h00, 8'h05);
    wr(8'h00, 8'h02);
    cyc(1);
    chk("lvi", o_low_voltage_interrupt, 8'h01);
    wr(8'h00, 8'h03);
    rd(8'h00, 8'h06);
    chk("lvi", o_low_voltage_interrupt, 8'h00);
    det(1'h0);
    rd(8'h00, 8'h03);
    wr(8'h00, 8'h05);
    rd(8'h00, 8'h00);
    wr(8'h03, 8'h02);
    rd(8'h03, 8'h01);
    $display("detect test done");
    i_vdd_below_lvr_assert <= 1'h1;
    i_vdd_above_lvr_deassert <= 1'h0;
    cyc(2);
    chk("lvr", o_low_voltage_reset_out, 8'h00);
    det(1'h1);
    chk("lvr", o_low_voltage_reset_out, 8'h01);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h04);
    i_stop_mode <= 1'h1;
    cyc(6);
    rd(8'h00, 8'h01);
    chk("mode", o_mode, 8'h02);
    chk("lvr", o_low_voltage_reset_out, 8'h00);
    chk("det_act", o_low_voltage_detector_active, 8'h00);
    i_stop_mode <= 1'h0;
    cyc(6);
    chk("lvr", o_low_voltage_reset_out, 8'h01);
    i_vdd_below_lvr_assert <= 1'h0;
    i_vdd_above_lvr_deassert <= 1'h1;
    cyc(6);
    chk("lvr", o_low_voltage_reset_out, 8'h00);
    rd(8'h01, 8'h03);
    $display("mode test done");
    // enable pin only moves while the part is held in reset
    i_rst_n <= 1'h0;
    i_regulator_enable_pin <= 1'h0;
    cyc(4);
    i_rst_n <= 1'h1;
    i_vdd_below_por <= 1'h1;
    cyc(6);
    chk("mode", o_mode, 8'h00);
    chk("drive", o_reg_outputs_drive, 8'h00);
    chk("por", o_por_out, 8'h01);
    $display("shutdown test done");
    final_report();
  end
endmodule
